/* File: hdl/mrp_pkg.sv */
// constants and types for the microphone recording bring-up controller
package mrp_pkg;

    // --------------------------------------------------------------
    // codec register addresses
    // --------------------------------------------------------------
    localparam logic [7:0] DEV_PWR_A  = 8'h00;
    localparam logic [7:0] DEV_GAIN_A = 8'h02;
    localparam logic [7:0] DEV_GAIN_B = 8'h03;
    localparam logic [7:0] DEV_FS     = 8'h05;
    localparam logic [7:0] DEV_TIMER  = 8'h06;
    localparam logic [7:0] DEV_MAIN   = 8'h07;
    localparam logic [7:0] DEV_REF    = 8'h08;
    localparam logic [7:0] DEV_INITIAL_VOLUME_VALUE   = 8'h09;
    localparam logic [7:0] DEV_AUX    = 8'h0b;
    localparam logic [7:0] DEV_PWR_B  = 8'h10;
    localparam logic [7:0] DEV_FSEL   = 8'h11;
    localparam logic [7:0] DEV_PATH   = 8'h26;

    // --------------------------------------------------------------
    // codec bit positions
    // --------------------------------------------------------------
    localparam int LEFT_ADC_POS  = 0;  // in DEV_PWR_A
    localparam int FILT_PWR_POS  = 7;  // in DEV_PWR_A
    localparam int RIGHT_ADC_POS = 0;  // in DEV_PWR_B
    localparam int LVL_EN_POS    = 5;  // in DEV_MAIN
    localparam int ADC_FILT_POS  = 0;  // in DEV_PATH
    localparam int FILT_SDO_POS  = 1;  // in DEV_PATH

    // --------------------------------------------------------------
    // software register map of the controller
    // --------------------------------------------------------------
    localparam logic [7:0] SW_CTRL     = 8'h00;
    localparam logic [7:0] SW_STATUS   = 8'h01;
    localparam logic [7:0] SW_COEF_CNT = 8'h02;
    localparam logic [7:0] SW_COEF_DAT = 8'h03;
    localparam logic [7:0] SW_CFG_BASE = 8'h10;
    localparam int CTRL_START_POS = 0;
    localparam int CTRL_STOP_POS  = 1;
    localparam int CTRL_PLL_POS   = 2;

    // shadow slots for values written to the codec
    localparam int CFG_N      = 12;
    localparam int CFG_FS     = 0;
    localparam int CFG_GAIN_A = 1;
    localparam int CFG_GAIN_B = 2;
    localparam int CFG_TIMER  = 3;
    localparam int CFG_REF    = 4;
    localparam int CFG_INITIAL_VOLUME_VALUE   = 5;
    localparam int CFG_AUX    = 6;
    localparam int CFG_MAIN   = 7;
    localparam int CFG_PATH   = 8;
    localparam int CFG_FSEL   = 9;
    localparam int CFG_PWR_A  = 10;
    localparam int CFG_PWR_B  = 11;
    localparam logic [7:0] CFG_RESET = 8'h00;

    // --------------------------------------------------------------
    // timing
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int PLL_LOCK_MS   = 10;
    localparam int PLL_LOCK_CYC  = (PLL_LOCK_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int COEF_DEPTH    = 48;

    typedef logic [CFG_N-1:0][7:0] mrp_cfg_t;

    typedef enum logic [4:0] {
        S_IDLE, S_CLKWAIT, S_FS, S_GAIN_A, S_GAIN_B, S_TIMER, S_REF, S_INITIAL_VOLUME_VALUE,
        S_AUX, S_MAIN, S_PATH, S_COEF, S_FSEL, S_LOCK, S_PWR_A, S_PWR_B,
        S_REC, S_DN_A, S_DN_B, S_ALC_OFF
    } mrp_step_t;

endpackage

/* File: hdl/mrp_ctrl.sv */
// host sequencer that brings the codec recording path up and down
//
// What this block does
// - start codec writes only after the clock-ready pin is seen high.
// - in PLL mode after a rate change, wait lock time before power-up.
// - write both microphone gain registers before powering the path.
// - write level timer and init-length select before enabling the path.
// - write level reference target before level control is enabled.
// - write initial volume before level control is enabled.
// - write auxiliary limiter and recovery bits before main level register.
// - then write the main level-control register from its shadow slot; the enable bit is not forced.
// - set filter-to-serial and adc-to-filter bits in filter path register.
// - load filter coefficients, then stage select, before filter power.
// - start recording by setting left, right ADC and filter power bits.
// - stop recording by clearing left, right ADC and filter power bits.
// - after power-down, clear the level-control enable bit.
`timescale 1ns/100ps
module mrp_ctrl #(
    parameter int LOCK_CYCLES = mrp_pkg::PLL_LOCK_CYC,
    parameter int COEF_DEPTH  = mrp_pkg::COEF_DEPTH
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // software register port
    input  wire logic [7:0]  sw_addr,
    input  wire logic [15:0] sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic      [15:0] sw_rdata,
    // codec register write port
    output logic      [7:0]  dev_addr,
    output logic      [7:0]  dev_data,
    output logic             dev_req,
    input  wire logic        dev_ack,
    // clock setup done, from a pin
    input  wire logic        clk_ready_pin,
    // status
    output logic             busy,
    output logic             recording
);

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    localparam int LW = $clog2(LOCK_CYCLES + 1);
    localparam int CW = $clog2(COEF_DEPTH + 1);

    typedef struct packed {
        mrp_pkg::mrp_step_t              step;
        mrp_pkg::mrp_cfg_t               cfg;
        logic [COEF_DEPTH-1:0][15:0]     coef;
        logic [CW-1:0]                   coef_cnt;
        logic [CW-1:0]                   coef_wptr;
        logic [CW-1:0]                   coef_idx;
        logic [LW-1:0]                   lock_cnt;
        logic [2:0]                      sync;
        logic                            clk_ok;
        logic                            pll;
        logic [7:0]                      fs_last;
        logic                            fs_known;
        logic                            req;
        logic [7:0]                      addr;
        logic [7:0]                      data;
        logic [15:0]                     rdata;
    } mrp_state_t;

    mrp_state_t st_ff;
    mrp_state_t nxt_st;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    // codec address for each write step
    function automatic logic [7:0] addr_of(mrp_pkg::mrp_step_t s, logic [15:0] ce);
        unique case (s)
            mrp_pkg::S_FS:      addr_of = mrp_pkg::DEV_FS;
            mrp_pkg::S_GAIN_A:  addr_of = mrp_pkg::DEV_GAIN_A;
            mrp_pkg::S_GAIN_B:  addr_of = mrp_pkg::DEV_GAIN_B;
            mrp_pkg::S_TIMER:   addr_of = mrp_pkg::DEV_TIMER;
            mrp_pkg::S_REF:     addr_of = mrp_pkg::DEV_REF;
            mrp_pkg::S_INITIAL_VOLUME_VALUE:    addr_of = mrp_pkg::DEV_INITIAL_VOLUME_VALUE;
            mrp_pkg::S_AUX:     addr_of = mrp_pkg::DEV_AUX;
            mrp_pkg::S_MAIN:    addr_of = mrp_pkg::DEV_MAIN;
            mrp_pkg::S_PATH:    addr_of = mrp_pkg::DEV_PATH;
            mrp_pkg::S_COEF:    addr_of = ce[15:8];
            mrp_pkg::S_FSEL:    addr_of = mrp_pkg::DEV_FSEL;
            mrp_pkg::S_PWR_A:   addr_of = mrp_pkg::DEV_PWR_A;
            mrp_pkg::S_PWR_B:   addr_of = mrp_pkg::DEV_PWR_B;
            mrp_pkg::S_DN_A:    addr_of = mrp_pkg::DEV_PWR_A;
            mrp_pkg::S_DN_B:    addr_of = mrp_pkg::DEV_PWR_B;
            mrp_pkg::S_ALC_OFF: addr_of = mrp_pkg::DEV_MAIN;
            default:            addr_of = 8'h00;
        endcase
    endfunction

    // codec data for each write step; power and enable bits are forced here
    function automatic logic [7:0] data_of(mrp_pkg::mrp_step_t s, mrp_pkg::mrp_cfg_t c,
                                           logic [15:0] ce);
        logic [7:0] pa;
        logic [7:0] pb;
        pa = '0;
        pb = '0;
        pa[mrp_pkg::LEFT_ADC_POS] = 1'b1;
        pa[mrp_pkg::FILT_PWR_POS] = 1'b1;
        pb[mrp_pkg::RIGHT_ADC_POS] = 1'b1;
        unique case (s)
            mrp_pkg::S_FS:      data_of = c[mrp_pkg::CFG_FS];
            mrp_pkg::S_GAIN_A:  data_of = c[mrp_pkg::CFG_GAIN_A];
            mrp_pkg::S_GAIN_B:  data_of = c[mrp_pkg::CFG_GAIN_B];
            mrp_pkg::S_TIMER:   data_of = c[mrp_pkg::CFG_TIMER];
            mrp_pkg::S_REF:     data_of = c[mrp_pkg::CFG_REF];
            mrp_pkg::S_INITIAL_VOLUME_VALUE:    data_of = c[mrp_pkg::CFG_INITIAL_VOLUME_VALUE];
            mrp_pkg::S_AUX:     data_of = c[mrp_pkg::CFG_AUX];
            mrp_pkg::S_MAIN:    data_of = c[mrp_pkg::CFG_MAIN];
            mrp_pkg::S_PATH: begin
                data_of = c[mrp_pkg::CFG_PATH];
                data_of[mrp_pkg::ADC_FILT_POS] = 1'b1;
                data_of[mrp_pkg::FILT_SDO_POS] = 1'b1;
            end
            mrp_pkg::S_COEF:    data_of = ce[7:0];
            mrp_pkg::S_FSEL:    data_of = c[mrp_pkg::CFG_FSEL];
            mrp_pkg::S_PWR_A:   data_of = c[mrp_pkg::CFG_PWR_A] | pa;
            mrp_pkg::S_PWR_B:   data_of = c[mrp_pkg::CFG_PWR_B] | pb;
            mrp_pkg::S_DN_A:    data_of = c[mrp_pkg::CFG_PWR_A] & ~pa;
            mrp_pkg::S_DN_B:    data_of = c[mrp_pkg::CFG_PWR_B] & ~pb;
            mrp_pkg::S_ALC_OFF: begin
                data_of = c[mrp_pkg::CFG_MAIN];
                data_of[mrp_pkg::LVL_EN_POS] = 1'b0;
            end
            default:            data_of = 8'h00;
        endcase
    endfunction

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    logic        sw_start;
    logic        sw_stop;
    logic [15:0] cur_coef;
    logic        fs_change;

    // start and stop are write pulses, not stored bits
    assign sw_start  = sw_wr && sw_addr == mrp_pkg::SW_CTRL && sw_wdata[mrp_pkg::CTRL_START_POS];
    assign sw_stop   = sw_wr && sw_addr == mrp_pkg::SW_CTRL && sw_wdata[mrp_pkg::CTRL_STOP_POS];
    assign cur_coef  = st_ff.coef[st_ff.coef_idx];
    assign fs_change = !st_ff.fs_known || st_ff.fs_last != st_ff.cfg[mrp_pkg::CFG_FS];

    always_comb begin
        nxt_st = st_ff;
        nxt_st.rdata = 16'h0000;
        // pin filter: change counts once the last two stages agree
        nxt_st.sync = {st_ff.sync[1:0], clk_ready_pin};
        if (st_ff.sync[2] == st_ff.sync[1]) begin
            nxt_st.clk_ok = st_ff.sync[2];
        end
        if (st_ff.lock_cnt != '0) begin
            nxt_st.lock_cnt = st_ff.lock_cnt - LW'(1);
        end

        // software writes
        if (sw_wr) begin
            if (sw_addr == mrp_pkg::SW_CTRL) begin
                nxt_st.pll = sw_wdata[mrp_pkg::CTRL_PLL_POS];
            end else if (sw_addr == mrp_pkg::SW_COEF_CNT) begin
                // a count past the table depth would read entries that do not exist
                if (sw_wdata > 16'(COEF_DEPTH)) begin
                    nxt_st.coef_cnt = CW'(COEF_DEPTH);
                end else begin
                    nxt_st.coef_cnt = CW'(sw_wdata);
                end
                nxt_st.coef_wptr = '0;
            end else if (sw_addr == mrp_pkg::SW_COEF_DAT) begin
                // writes past the end are dropped
                if (st_ff.coef_wptr < CW'(COEF_DEPTH)) begin
                    nxt_st.coef[st_ff.coef_wptr] = sw_wdata;
                    nxt_st.coef_wptr = st_ff.coef_wptr + CW'(1);
                end
            end else if (sw_addr >= mrp_pkg::SW_CFG_BASE &&
                         sw_addr <  mrp_pkg::SW_CFG_BASE + 8'(mrp_pkg::CFG_N)) begin
                nxt_st.cfg[sw_addr - mrp_pkg::SW_CFG_BASE] = sw_wdata[7:0];
            end
        end

        // software reads, data valid in the following cycle only
        if (sw_rd) begin
            if (sw_addr == mrp_pkg::SW_CTRL) begin
                nxt_st.rdata[mrp_pkg::CTRL_PLL_POS] = st_ff.pll;
            end else if (sw_addr == mrp_pkg::SW_STATUS) begin
                nxt_st.rdata = {8'h00, st_ff.clk_ok, st_ff.lock_cnt != '0, st_ff.req, 5'(st_ff.step)};
            end else if (sw_addr == mrp_pkg::SW_COEF_CNT) begin
                nxt_st.rdata = 16'(st_ff.coef_cnt);
            end else if (sw_addr >= mrp_pkg::SW_CFG_BASE &&
                         sw_addr <  mrp_pkg::SW_CFG_BASE + 8'(mrp_pkg::CFG_N)) begin
                nxt_st.rdata = {8'h00, st_ff.cfg[sw_addr - mrp_pkg::SW_CFG_BASE]};
            end
        end

        // bring-up and shut-down sequence
        unique case (st_ff.step)
            mrp_pkg::S_IDLE: begin
                if (sw_start) begin
                    nxt_st.step = mrp_pkg::S_CLKWAIT;
                end
            end
            mrp_pkg::S_CLKWAIT: begin
                if (st_ff.clk_ok) begin
                    nxt_st.step = mrp_pkg::S_FS;
                end
            end
            mrp_pkg::S_LOCK: begin
                // power stays off until the PLL has had its full lock time
                if (st_ff.lock_cnt == '0) begin
                    nxt_st.step = mrp_pkg::S_PWR_A;
                end
            end
            mrp_pkg::S_REC: begin
                if (sw_stop) begin
                    nxt_st.step = mrp_pkg::S_DN_A;
                end
            end
            mrp_pkg::S_FS, mrp_pkg::S_GAIN_A, mrp_pkg::S_GAIN_B, mrp_pkg::S_TIMER,
            mrp_pkg::S_REF, mrp_pkg::S_INITIAL_VOLUME_VALUE, mrp_pkg::S_AUX, mrp_pkg::S_MAIN,
            mrp_pkg::S_PATH, mrp_pkg::S_COEF, mrp_pkg::S_FSEL, mrp_pkg::S_PWR_A,
            mrp_pkg::S_PWR_B, mrp_pkg::S_DN_A, mrp_pkg::S_DN_B, mrp_pkg::S_ALC_OFF: begin
                if (!st_ff.req) begin
                    // one write per step, S_COEF one per coefficient and skipped when the count is zero, in the fixed order of the enum
                    nxt_st.req  = 1'b1;
                    nxt_st.addr = addr_of(st_ff.step, cur_coef);
                    nxt_st.data = data_of(st_ff.step, st_ff.cfg, cur_coef);
                end else if (dev_ack) begin
                    nxt_st.req  = 1'b0;
                    nxt_st.step = mrp_pkg::mrp_step_t'(5'(st_ff.step) + 5'd1);
                    if (st_ff.step == mrp_pkg::S_FS) begin
                        nxt_st.fs_known = 1'b1;
                        nxt_st.fs_last  = st_ff.cfg[mrp_pkg::CFG_FS];
                        if (st_ff.pll && fs_change) begin
                            nxt_st.lock_cnt = LW'(LOCK_CYCLES);
                        end
                    end
                    if (st_ff.step == mrp_pkg::S_PATH && st_ff.coef_cnt == '0) begin
                        nxt_st.step = mrp_pkg::S_FSEL;
                    end
                    if (st_ff.step == mrp_pkg::S_COEF) begin
                        // coefficients first, stage select after the last one
                        nxt_st.coef_idx = st_ff.coef_idx + CW'(1);
                        if (st_ff.coef_idx + CW'(1) < st_ff.coef_cnt) begin
                            nxt_st.step = mrp_pkg::S_COEF;
                        end else begin
                            nxt_st.coef_idx = '0;
                        end
                    end
                    if (st_ff.step == mrp_pkg::S_ALC_OFF) begin
                        nxt_st.step = mrp_pkg::S_IDLE;
                    end
                end
            end
        endcase
    end

    // --------------------------------------------------------------
    // registers and outputs
    // --------------------------------------------------------------
    // coefficient table sits in flops; the idle reset keeps it clean
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign sw_rdata  = st_ff.rdata;
    assign dev_addr  = st_ff.addr;
    assign dev_data  = st_ff.data;
    assign dev_req   = st_ff.req;
    assign busy      = st_ff.step != mrp_pkg::S_IDLE && st_ff.step != mrp_pkg::S_REC;
    assign recording = st_ff.step == mrp_pkg::S_REC;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    AST_CLK_FIRST: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(st_ff.req) && st_ff.step == mrp_pkg::S_FS
        |-> $past(st_ff.clk_ok, 2))
        else $error("codec write before clock setup");

    AST_LOCK_WAIT: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_ff.step == mrp_pkg::S_PWR_A && st_ff.req
        |-> st_ff.lock_cnt == '0)
        else $error("power up before pll lock time");

    AST_GAIN_ORDER: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_ff.step == mrp_pkg::S_GAIN_B && st_ff.req && dev_ack
        |=> st_ff.step == mrp_pkg::S_TIMER)
        else $error("gain writes out of order");

    AST_GAIN_ADDR: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_ff.req && st_ff.step inside {mrp_pkg::S_GAIN_A, mrp_pkg::S_GAIN_B}
        |-> dev_addr == (st_ff.step == mrp_pkg::S_GAIN_A ? 8'h02 : 8'h03))
        else $error("gain write to wrong address");

    AST_TIMER_ADDR: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_ff.step == mrp_pkg::S_TIMER && st_ff.req
        |-> dev_addr == 8'h06)
        else $error("timer write to wrong address");

    AST_REF_DATA: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_ff.step == mrp_pkg::S_REF && st_ff.req |-> dev_addr == 8'h08
        && dev_data == st_ff.cfg[mrp_pkg::CFG_REF])
        else $error("reference write wrong");

    AST_INITIAL_VOLUME_VALUE_ADDR: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_ff.step == mrp_pkg::S_INITIAL_VOLUME_VALUE && st_ff.req
        |-> dev_addr == 8'h09)
        else $error("initial volume write wrong");

    AST_AUX_THEN_MAIN: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_ff.step == mrp_pkg::S_AUX && st_ff.req && dev_ack |=> st_ff.step == mrp_pkg::S_MAIN
        ##1 dev_req && dev_addr == 8'h07)
        else $error("main level write not after aux");

    AST_MAIN_ADDR: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_ff.step == mrp_pkg::S_MAIN && st_ff.req
        |-> dev_addr == 8'h07)
        else $error("main level write wrong address");

    AST_PATH_BITS: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_ff.step == mrp_pkg::S_PATH && st_ff.req
        |-> dev_addr == 8'h26 && dev_data[1:0] == 2'b11)
        else $error("filter path bits not set");

    AST_COEF_BEFORE_SEL: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_ff.step == mrp_pkg::S_FSEL |-> $past(st_ff.step) inside {mrp_pkg::S_FSEL,
        mrp_pkg::S_COEF, mrp_pkg::S_PATH})
        else $error("stage select before coefficients");

    AST_PWR_AFTER_SEL: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_ff.step == mrp_pkg::S_PWR_A
        |-> $past(st_ff.step) inside {mrp_pkg::S_LOCK, mrp_pkg::S_PWR_A})
        else $error("filter power before stage select");

    AST_PWR_UP: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_ff.step == mrp_pkg::S_PWR_A && st_ff.req
        |-> dev_data[7] && dev_data[0])
        else $error("power up bits missing");

    AST_PWR_DN_A: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_ff.step == mrp_pkg::S_DN_A && st_ff.req
        |-> dev_addr == 8'h00 && !dev_data[7] && !dev_data[0])
        else $error("left adc or filter not powered down");

    AST_PWR_DN: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_ff.step == mrp_pkg::S_DN_B && st_ff.req
        |-> !dev_data[0] && dev_addr == 8'h10)
        else $error("right adc not powered down");

    AST_ALC_BIT_CLR: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_ff.step == mrp_pkg::S_ALC_OFF && st_ff.req
        |-> dev_addr == 8'h07 && !dev_data[5])
        else $error("level enable not cleared");

    AST_ALC_OFF: assert property (@(posedge clk_sys) disable iff (!rst_b)
        st_ff.step == mrp_pkg::S_ALC_OFF && st_ff.req && dev_ack
        |=> !dev_req ##1 !busy)
        else $error("level control disable not last");

endmodule

/* File: sim/mrp_dev_model.sv */
// behavioural codec register model facing the recording controller
`timescale 1ns/100ps
module mrp_dev_model #(
    parameter int INIT_SAMPLES = 1059,
    parameter int SAMPLE_DIV   = 2
) (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst_b,
    // codec register write port
    input  wire logic [7:0] dev_addr,
    input  wire logic [7:0] dev_data,
    input  wire logic       dev_req,
    output logic            dev_ack,
    // bench controls and observed audio side
    input  wire logic [3:0] ack_delay,
    output logic      [7:0] sample_out,
    output logic      [7:0] level_gain
);
    logic [7:0] regs [0:255];
    logic [7:0] log_addr [$];
    logic [7:0] log_data [$];
    int         wait_cnt;
    int         init_cnt;
    int         div_cnt;
    logic       adc_up;

    initial begin
        foreach (regs[i]) regs[i] = 8'h00;
    end

    // ack after a chosen delay; each accepted write is logged
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dev_ack <= 1'b0;
            wait_cnt = 0;
        end else if (dev_ack) begin
            dev_ack <= 1'b0;
        end else if (dev_req) begin
            if (wait_cnt >= int'(ack_delay)) begin
                dev_ack <= 1'b1;
                wait_cnt = 0;
                regs[dev_addr] <= dev_data;
                log_addr.push_back(dev_addr);
                log_data.push_back(dev_data);
            end else begin
                wait_cnt++;
            end
        end
    end

    // adc init cycle counted in sample ticks; restarts on every power-down
    assign adc_up = regs[8'h00][0] & regs[8'h10][0];
    always @(posedge clk_sys) begin
        div_cnt = (div_cnt + 1) % SAMPLE_DIV;
        if (!adc_up) init_cnt = 0;
        else if (div_cnt == 0 && init_cnt < INIT_SAMPLES) init_cnt++;
    end

    // zero samples while down or initialising
    assign sample_out = (adc_up && init_cnt == INIT_SAMPLES) ? 8'h5a : 8'h00;
    // level control starts from the programmed initial volume
    assign level_gain = regs[8'h07][5] ? regs[8'h09] : 8'h00;
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the recording bring-up controller
`timescale 1ns/100ps
module testbench;
    logic        clk_sys, rst_b, sw_wr, sw_rd, dev_req, dev_ack, clk_ready_pin, busy, recording;
    logic [7:0]  sw_addr, dev_addr, dev_data, sample_out, level_gain;
    logic [15:0] sw_wdata, sw_rdata;
    logic [3:0]  ack_delay;
    int          bad_count, total_checks;
    logic [7:0]  cfg [0:11] = '{8'h27, 8'h05, 8'h00, 8'hf0, 8'he1, 8'he1, 8'h00, 8'ha1, 8'h00, 8'h01, 8'h40, 8'h00};
    logic [15:0] up_seq [0:13] = '{16'h0527, 16'h0205, 16'h0300, 16'h06f0, 16'h08e1, 16'h09e1, 16'h0b00,
                                   16'h07a1, 16'h2603, 16'h2880, 16'h1234, 16'h1101, 16'h00c1, 16'h1001};
    logic [15:0] dn_seq [0:2] = '{16'h0040, 16'h1000, 16'h0781};

    mrp_ctrl #(.LOCK_CYCLES(200), .COEF_DEPTH(48)) i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .dev_addr(dev_addr),
        .dev_data(dev_data), .dev_req(dev_req), .dev_ack(dev_ack), .clk_ready_pin(clk_ready_pin),
        .busy(busy), .recording(recording));
    mrp_dev_model #(.INIT_SAMPLES(1059), .SAMPLE_DIV(2)) i_dev (.clk_sys(clk_sys), .rst_b(rst_b),
        .dev_addr(dev_addr), .dev_data(dev_data), .dev_req(dev_req), .dev_ack(dev_ack),
        .ack_delay(ack_delay), .sample_out(sample_out), .level_gain(level_gain));

    // ----------------------------------------------------------
    // bus tasks and checking
    // ----------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic sw_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        sw_wr <= 1'b1;
        sw_addr <= a;
        sw_wdata <= d;
        @(posedge clk_sys);
        sw_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic sw_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        sw_rd <= 1'b1;
        sw_addr <= a;
        @(posedge clk_sys);
        sw_rd <= 1'b0;
        #1 d = sw_rdata;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------
    task automatic t_regs();
        logic [15:0] d;
        sw_read(8'h10, d);
        chk("shadow reset", d, 16'h0000);
        sw_write(8'h7f, 16'hffff);
        sw_read(8'h7f, d);
        chk("unmapped read", d, 16'h0000);
        for (int i = 0; i < 12; i++) sw_write(8'(mrp_pkg::SW_CFG_BASE + i), {8'h00, cfg[i]});
        for (int i = 0; i < 12; i++) begin
            sw_read(8'(mrp_pkg::SW_CFG_BASE + i), d);
            chk("shadow readback", d, {8'h00, cfg[i]});
        end
    endtask
    // start with the clock pin low: nothing may reach the codec yet
    task automatic t_bringup();
        logic [15:0] d;
        bit          lock_seen;
        bit          lock_step;
        lock_seen = 0;
        lock_step = 0;
        sw_write(mrp_pkg::SW_COEF_CNT, 16'h0002);
        sw_write(mrp_pkg::SW_COEF_DAT, 16'h2880);
        sw_write(mrp_pkg::SW_COEF_DAT, 16'h1234);
        sw_write(mrp_pkg::SW_CTRL, 16'h0005);
        repeat (10) @(posedge clk_sys);
        sw_read(mrp_pkg::SW_STATUS, d);
        chk("held step", {11'h0, d[4:0]}, 16'h0001);
        chk("early writes", 16'(i_dev.log_addr.size()), 16'h0000);
        chk("busy in clock wait", {15'h0, busy}, 16'h0001);
        @(posedge clk_sys);
        clk_ready_pin <= 1'b1;
        for (int i = 0; i < 2000 && recording !== 1'b1; i++) begin
            sw_read(mrp_pkg::SW_STATUS, d);
            if (d[6] === 1'b1) lock_seen = 1;
            if (d[4:0] === 5'd13) begin
                lock_step = 1;
                chk("writes in lock", 16'(i_dev.log_addr.size()), 16'd12);
            end
        end
        chk("lock wait seen", {15'h0, lock_seen}, 16'h0001);
        chk("lock step seen", {15'h0, lock_step}, 16'h0001);
        chk("bring-up count", 16'(i_dev.log_addr.size()), 16'd14);
        for (int i = 0; i < 14; i++) chk("bring-up write", {i_dev.log_addr[i], i_dev.log_data[i]}, up_seq[i]);
    endtask
    task automatic t_samples();
        chk("init samples", {8'h00, sample_out}, 16'h0000);
        chk("start gain", {8'h00, level_gain}, 16'h00e1);
        repeat (2000) @(posedge clk_sys);
        #1 chk("late init samples", {8'h00, sample_out}, 16'h0000);
        repeat (200) @(posedge clk_sys);
        #1 chk("live samples", {8'h00, sample_out}, 16'h005a);
        sw_write(mrp_pkg::SW_CTRL, 16'h0005);
        repeat (5) @(posedge clk_sys);
        #1 chk("start ignored", {15'h0, recording}, 16'h0001);
        chk("no extra writes", 16'(i_dev.log_addr.size()), 16'd14);
    endtask
    // prompt acks on the way down; a second stop must do nothing
    task automatic t_stop();
        @(posedge clk_sys);
        ack_delay <= 4'h0;
        sw_write(mrp_pkg::SW_CTRL, 16'h0006);
        @(posedge clk_sys);
        #1 chk("busy on stop", {15'h0, busy}, 16'h0001);
        for (int i = 0; i < 300; i++) begin
            @(posedge clk_sys);
            #1;
            if (busy === 1'b0 && recording === 1'b0) break;
        end
        chk("down count", 16'(i_dev.log_addr.size()), 16'd17);
        for (int i = 0; i < 3; i++) chk("down write", {i_dev.log_addr[14+i], i_dev.log_data[14+i]}, dn_seq[i]);
        sw_write(mrp_pkg::SW_CTRL, 16'h0006);
        repeat (5) @(posedge clk_sys);
        chk("stop ignored", 16'(i_dev.log_addr.size()), 16'd17);
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    // watchdog sized well past the longest expected run
    initial begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        {rst_b, sw_wr, sw_rd, clk_ready_pin, sw_addr, sw_wdata} = '0;
        ack_delay = 4'h3;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_regs();
        t_bringup();
        t_samples();
        t_stop();
        tally_and_finish();
    end
endmodule
